//--- frbus_host.sv
// module: host controller driving the shared flash/ram package bus
`timescale 1ns/1ns
`default_nettype none
module frbus_host
	import frbus_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_req,
	input wire logic i_die,
	input wire logic i_write,
	input wire logic [FRBUS_FADDR_W-1:0] i_addr,
	input wire logic [FRBUS_DATA_W-1:0] i_wdata,
	input wire logic [1:0] i_byte_en,
	input wire logic i_flash_reset,
	input wire logic i_boot_protect,
	input wire logic i_ram_deep_sleep,
	input wire logic [FRBUS_DATA_W-1:0] i_dq,
	input wire logic i_ready_busy_out,
	output logic o_busy,
	output logic o_done,
	output logic [FRBUS_DATA_W-1:0] o_rdata,
	output logic o_flash_ready,
	output logic [1:0] o_flash_bank,
	output logic [FRBUS_FADDR_W-1:0] o_addr,
	output logic [FRBUS_DATA_W-1:0] o_dq,
	output logic [1:0] o_dq_oe,
	output logic o_flash_chip_select_n,
	output logic o_ram_chip_select_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic o_low_byte_select_n,
	output logic o_high_byte_select_n,
	output logic o_ram_mode,
	output logic o_flash_reset_n,
	output logic o_boot_protect_accel_n
);
	typedef struct packed {
		frbus_state_t st;
		logic busy;
		logic done;
		logic [FRBUS_DATA_W-1:0] rdata;
		logic ready;
		logic [1:0] bank;
		logic [FRBUS_FADDR_W-1:0] addr;
		logic [FRBUS_DATA_W-1:0] dq;
		logic [1:0] dq_oe;
		logic fcs_n;
		logic rcs_n;
		logic oe_n;
		logic we_n;
		logic lb_n;
		logic ub_n;
		logic mode;
		logic frst_n;
		logic wp_n;
		logic write;
		logic die;
	} frbus_host_state_t;
	frbus_host_state_t s, next_s;
	logic tmr_load;
	logic [FRBUS_CNT_W-1:0] tmr_count;
	logic tmr_done;

	frbus_strobe_timer u_timer (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_load(tmr_load),
		.i_count(tmr_count),
		.o_done(tmr_done)
	);

	always_comb
	begin
		next_s = s;
		tmr_load = 1'b0;
		tmr_count = FRBUS_CNT_W'(FRBUS_STROBE_CYC);
		next_s.done = 1'b0;
		next_s.ready = i_ready_busy_out;
		next_s.frst_n = !i_flash_reset;
		next_s.wp_n = !i_boot_protect;
		unique case (s.st)
			FRBUS_IDLE:
			begin
				// deep sleep only while ram is deselected
				next_s.mode = !i_ram_deep_sleep;
				next_s.fcs_n = 1'b1;
				next_s.rcs_n = 1'b1;
				next_s.oe_n = 1'b1;
				next_s.we_n = 1'b1;
				next_s.lb_n = 1'b1;
				next_s.ub_n = 1'b1;
				next_s.dq_oe = 2'h0;
				if (i_req && !(i_die == FRBUS_DIE_FLASH && i_flash_reset))
				begin
					next_s.st = FRBUS_STROBE;
					next_s.busy = 1'b1;
					next_s.write = i_write;
					next_s.die = i_die;
					next_s.addr = i_addr;
					next_s.bank = frbus_bank(i_addr);
					next_s.oe_n = i_write;
					next_s.we_n = !i_write;
					tmr_load = 1'b1;
					if (i_die == FRBUS_DIE_RAM)
					begin
						next_s.mode = 1'b1;
						next_s.rcs_n = 1'b0;
						next_s.lb_n = !i_byte_en[0];
						next_s.ub_n = !i_byte_en[1];
						next_s.addr = {2'h0, i_addr[FRBUS_RADDR_W-1:0]};
						next_s.dq_oe = i_write ? i_byte_en : 2'h0;
					end
					else
					begin
						next_s.mode = 1'b1;
						next_s.fcs_n = 1'b0;
						next_s.dq_oe = i_write ? 2'h3 : 2'h0;
					end
					next_s.dq = i_wdata;
				end
			end
			FRBUS_STROBE:
			begin
				if (tmr_done)
				begin
					if (!s.write)
						next_s.rdata = i_dq;
					next_s.oe_n = 1'b1;
					next_s.we_n = 1'b1;
					next_s.st = FRBUS_RECOVER;
					tmr_load = 1'b1;
					tmr_count = FRBUS_CNT_W'(FRBUS_RECOVER_CYC);
				end
			end
			FRBUS_RECOVER:
			begin
				if (tmr_done)
				begin
					next_s.fcs_n = 1'b1;
					next_s.rcs_n = 1'b1;
					next_s.lb_n = 1'b1;
					next_s.ub_n = 1'b1;
					next_s.dq_oe = 2'h0;
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
					next_s.st = FRBUS_IDLE;
				end
			end
			default:
				next_s.st = FRBUS_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s <= '0;
			s.st <= FRBUS_IDLE;
			s.fcs_n <= 1'b1;
			s.rcs_n <= 1'b1;
			s.oe_n <= 1'b1;
			s.we_n <= 1'b1;
			s.lb_n <= 1'b1;
			s.ub_n <= 1'b1;
			s.mode <= 1'b1;
			s.frst_n <= 1'b1;
			s.wp_n <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign o_busy = s.busy;
	assign o_done = s.done;
	assign o_rdata = s.rdata;
	assign o_flash_ready = s.ready;
	assign o_flash_bank = s.bank;
	assign o_addr = s.addr;
	assign o_dq = s.dq;
	assign o_dq_oe = s.dq_oe;
	assign o_flash_chip_select_n = s.fcs_n;
	assign o_ram_chip_select_n = s.rcs_n;
	assign o_oe_n = s.oe_n;
	assign o_we_n = s.we_n;
	assign o_low_byte_select_n = s.lb_n;
	assign o_high_byte_select_n = s.ub_n;
	assign o_ram_mode = s.mode;
	assign o_flash_reset_n = s.frst_n;
	assign o_boot_protect_accel_n = s.wp_n;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	never_both_a: assert property (!(!s.fcs_n && !s.rcs_n))
		else $error("both dies selected");
	ram_flash_idle_a: assert property (!s.rcs_n |-> (s.fcs_n || !s.frst_n))
		else $error("flash active during ram access");
	mode_high_a: assert property (!s.rcs_n |-> s.mode)
		else $error("mode low during ram access");
	oe_we_excl_a: assert property (!(!s.oe_n && !s.we_n))
		else $error("oe and we both low");
	lane_gate_a: assert property (!s.rcs_n && !s.we_n |-> (s.dq_oe == {!s.ub_n, !s.lb_n}))
		else $error("lane drive mismatch");
	no_drive_read_a: assert property (!s.oe_n |-> s.dq_oe == 2'h0)
		else $error("host drives during read");
	strobe_len_a: assert property ($fell(s.oe_n) || $fell(s.we_n)
		|-> (!s.oe_n || !s.we_n) [*3] ##1 (s.oe_n && s.we_n))
		else $error("strobe width wrong");
	done_follows_a: assert property ($rose(s.busy) |-> ##[4:8] s.done)
		else $error("transfer did not finish");
	reset_follow_a: assert property (i_flash_reset |=> !s.frst_n)
		else $error("flash reset not driven");
	protect_follow_a: assert property (i_boot_protect |=> !s.wp_n)
		else $error("boot protect not driven");
	ram_write_c: cover property (!s.rcs_n && !s.we_n);
	ram_read_c: cover property (!s.rcs_n && !s.oe_n);
	flash_write_c: cover property (!s.fcs_n && !s.we_n);
	flash_read_c: cover property (!s.fcs_n && !s.oe_n);
endmodule : frbus_host
`default_nettype wire

//--- frbus_pkg.sv
// package: constants and types for the flash/ram shared bus host controller
// Notes on behaviour
// - slash-named control pins are active low
// - drive only listed pin combinations
// - ram deselected during any flash access
// - flash standby or reset during ram access
// - flash read tolerates write enable low
// - standby-mode select high during ram access
// - protection and id through command sequences
package frbus_pkg;
	localparam int FRBUS_DATA_W = 16;
	localparam int FRBUS_FADDR_W = 22;
	localparam int FRBUS_RADDR_W = 20;
	localparam int FRBUS_CLK_MHZ = 20;
	// access strobe width and turnaround, in ns
	localparam int FRBUS_STROBE_NS = 100;
	localparam int FRBUS_STROBE_CYC = (FRBUS_STROBE_NS * FRBUS_CLK_MHZ + 999) / 1000;
	localparam int FRBUS_RECOVER_NS = 50;
	localparam int FRBUS_RECOVER_CYC = (FRBUS_RECOVER_NS * FRBUS_CLK_MHZ + 999) / 1000;
	localparam int FRBUS_CNT_W = 4;
	// flash bank boundaries (word address bits 21:19)
	localparam logic [2:0] FRBUS_BANK_A_TOP = 3'h0;
	localparam logic [2:0] FRBUS_BANK_C_TOP = 3'h6;
	localparam int FRBUS_SECTORS = 142;
	typedef enum logic [1:0] {FRBUS_OP_READ, FRBUS_OP_WRITE} frbus_op_t;
	typedef enum logic {FRBUS_DIE_FLASH, FRBUS_DIE_RAM} frbus_die_t;
	typedef enum logic [1:0] {FRBUS_IDLE, FRBUS_STROBE, FRBUS_RECOVER} frbus_state_t;

	// bank index 0..3 from a flash word address
	function automatic logic [1:0] frbus_bank(input logic [FRBUS_FADDR_W-1:0] addr);
		logic [2:0] top;
		top = addr[FRBUS_FADDR_W-1 -: 3];
		if (top == FRBUS_BANK_A_TOP)
			return 2'h0;
		else if (top < 3'h4)
			return 2'h1;
		else if (top <= FRBUS_BANK_C_TOP)
			return 2'h2;
		else
			return 2'h3;
	endfunction : frbus_bank
endpackage : frbus_pkg

//--- frbus_strobe_timer.sv
// module: down-counter that times bus strobe phases
`timescale 1ns/1ns
`default_nettype none
module frbus_strobe_timer
	import frbus_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_load,
	input wire logic [FRBUS_CNT_W-1:0] i_count,
	output logic o_done
);
	typedef struct packed {
		logic [FRBUS_CNT_W-1:0] cnt;
		logic done;
	} frbus_tmr_t;
	frbus_tmr_t s, next_s;

	always_comb
	begin
		next_s = s;
		if (i_load)
		begin
			next_s.cnt = i_count;
			next_s.done = 1'b0;
		end
		else if (s.cnt != '0)
		begin
			next_s.cnt = s.cnt - 1'b1;
			next_s.done = (s.cnt == 4'h1);
		end
		else
			next_s.done = 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign o_done = s.done;
endmodule : frbus_strobe_timer
`default_nettype wire

//--- frbus_dev_model.sv
// device model: flash and ram dies on the shared package bus
`timescale 1ns/1ns
`default_nettype none
module frbus_dev_model
	import frbus_pkg::*;
(
	input wire logic i_clk,
	input wire logic [FRBUS_FADDR_W-1:0] i_addr,
	input wire logic [FRBUS_DATA_W-1:0] i_dq,
	input wire logic i_fcs_n,
	input wire logic i_rcs_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_lb_n,
	input wire logic i_ub_n,
	input wire logic i_mode,
	input wire logic i_rst_n,
	input wire logic i_wp_n,
	output logic [FRBUS_DATA_W-1:0] o_dq,
	output logic o_ready_busy
);
	logic [15:0] ram [int];
	logic [15:0] rd;
	logic [15:0] en;
	logic [15:0] prev;
	logic tog = 1'h0;
	logic we_q = 1'h1;
	logic held = 1'h0;
	logic [5:0] prog_cnt = 6'h0;
	logic [1:0] prog_bank = 2'h0;
	wire logic fr = i_rst_n && !i_fcs_n && !i_oe_n;
	wire logic rr = !i_rcs_n && i_mode && !i_oe_n && i_we_n;
	// bank from the top address bits: 8, 24, 24, 8 megabits
	function automatic logic [1:0] bank_of(input logic [21:0] a);
		if (a[21:19] == 3'h0)
			return 2'h0;
		else if (a[21:19] < 3'h4)
			return 2'h1;
		else if (a[21:19] < 3'h7)
			return 2'h2;
		else
			return 2'h3;
	endfunction : bank_of
	// eight small sectors at each end, large ones between
	function automatic int sector_of(input logic [21:0] a);
		if (a[21:15] == 7'h00)
			return int'(a[14:12]);
		else if (a[21:15] == 7'h7f)
			return 134 + int'(a[14:12]);
		else
			return 7 + int'(a[21:15]);
	endfunction : sector_of
	always @(posedge i_clk) tog <= !tog;
	always @(posedge i_clk) we_q <= i_we_n;
	// embedded program: busy for a fixed span, suspend and resume by command word
	always @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
		begin
			prog_cnt <= 6'h0;
			held <= 1'h0;
		end
		else
		begin
			if (prog_cnt != 6'h0 && !held)
				prog_cnt <= prog_cnt - 6'h1;
			if (i_we_n && !we_q && !i_fcs_n)
			begin
				if (prog_cnt != 6'h0)
					held <= (i_dq == 16'h00b0) || (held && i_dq != 16'h0030);
				else if (i_wp_n || (sector_of(i_addr) > 7 && sector_of(i_addr) < 134))
				begin
					prog_cnt <= 6'h28;
					prog_bank <= bank_of(i_addr);
				end
			end
		end
	assign o_ready_busy = (prog_cnt == 6'h0) || held;
	always_comb
	begin
		rd = i_addr[15:0] ^ 16'h5a5a;
		// the bank being programmed answers with status, the others read normally
		if (prog_cnt != 6'h0 && !held && bank_of(i_addr) == prog_bank)
			rd = 16'h0040;
		en = {16{fr}};
		if (rr)
		begin
			rd = ram.exists(int'(i_addr[19:0])) ? ram[int'(i_addr[19:0])] : 16'h0;
			en = {{8{!i_ub_n}}, {8{!i_lb_n}}};
		end
		// released lanes toggle so a stale value cannot pass
		o_dq = (rd & en) | (({16{tog}} ^ 16'hc3c3) & ~en);
	end
	always @(posedge i_we_n)
		if (!i_rcs_n && i_mode)
		begin
			prev = ram.exists(int'(i_addr[19:0])) ? ram[int'(i_addr[19:0])] : 16'h0;
			ram[int'(i_addr[19:0])] = {i_ub_n ? prev[15:8] : i_dq[15:8],
				i_lb_n ? prev[7:0] : i_dq[7:0]};
		end
	// deselect with mode low drops data, mode high keeps it
	always @(negedge i_mode)
		if (i_rcs_n)
			ram.delete();
endmodule : frbus_dev_model
`default_nettype wire

//--- flash_ram_shared_bus_decode_test.sv
// testbench: host controller against the device model
`timescale 1ns/1ns
`default_nettype none
module flash_ram_shared_bus_decode_test;
	import frbus_pkg::*;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic req = 1'h0, die = 1'h0, wr = 1'h0, frst = 1'h0, bprot = 1'h0, sleep = 1'h0, rdy = 1'h1;
	logic [21:0] addr = 22'h0;
	logic [15:0] wd = 16'h0;
	logic [1:0] be = 2'h3;
	logic [15:0] dq, rdata, odq;
	logic [21:0] pa;
	logic [1:0] oe2, bank;
	logic busy, done, frdy, fcs, rcs, oe, we, lb, ub, mode, frn, bpn, mrdy;
	logic [8:0] snap;
	int mismatches = 0, comparisons = 0, lat;
	always #25 clk = !clk;
	frbus_host DUT (.i_clk(clk), .i_rstn(rstn), .i_req(req), .i_die(die), .i_write(wr),
		.i_addr(addr), .i_wdata(wd), .i_byte_en(be), .i_flash_reset(frst),
		.i_boot_protect(bprot), .i_ram_deep_sleep(sleep), .i_dq(dq),
		.i_ready_busy_out(rdy & mrdy),
		.o_busy(busy), .o_done(done), .o_rdata(rdata), .o_flash_ready(frdy),
		.o_flash_bank(bank), .o_addr(pa), .o_dq(odq), .o_dq_oe(oe2),
		.o_flash_chip_select_n(fcs), .o_ram_chip_select_n(rcs), .o_oe_n(oe), .o_we_n(we),
		.o_low_byte_select_n(lb), .o_high_byte_select_n(ub), .o_ram_mode(mode),
		.o_flash_reset_n(frn), .o_boot_protect_accel_n(bpn));
	frbus_dev_model model (.i_clk(clk), .i_addr(pa), .i_dq(odq), .i_fcs_n(fcs),
		.i_rcs_n(rcs), .i_oe_n(oe), .i_we_n(we), .i_lb_n(lb), .i_ub_n(ub), .i_mode(mode),
		.i_rst_n(frn), .i_wp_n(bpn), .o_dq(dq), .o_ready_busy(mrdy));
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// one access; pins snapshot in the strobe, latency counted from taking edge
	task acc(input logic d, input logic w, input logic [21:0] a, input logic [15:0] v,
		input logic [1:0] b);
		@(posedge clk);
		#5 {die, wr, addr, wd, be} = {d, w, a, v, b};
		req = 1'h1;
		@(posedge clk);
		#5 req = 1'h0;
		lat = 0;
		while (done !== 1'h1 && lat < 20)
		begin
			@(posedge clk);
			#1 lat++;
			if (lat == 1)
				snap = {fcs, rcs, oe, we, lb, ub, mode, oe2};
		end
		chk(lat, FRBUS_STROBE_CYC + FRBUS_RECOVER_CYC + 2);
	endtask : acc
	task t_flash;
		acc(1'h0, 1'h0, 22'h123456, 16'h0, 2'h3);
		chk(snap & 9'h1e7, 9'h0a4);
		chk(rdata, 16'h6e0c);
		acc(1'h0, 1'h1, 22'h0, 16'h00aa, 2'h3);
		chk(snap & 9'h1e7, 9'h0c7);
	endtask : t_flash
	task t_bank;
		logic [21:0] ba [5] = '{22'h0, 22'h07ffff, 22'h080000, 22'h37ffff, 22'h380000};
		logic [1:0] bx [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
		for (int i = 0; i < 5; i++)
		begin
			acc(1'h0, 1'h0, ba[i], 16'h0, 2'h3);
			chk(bank, bx[i]);
		end
	endtask : t_bank
	task t_ram;
		acc(1'h1, 1'h1, 22'h0abcd, 16'h1234, 2'h3);
		chk(snap, 9'h147);
		acc(1'h1, 1'h1, 22'h0abcd, 16'hffee, 2'h1);
		chk(snap, 9'h14d);
		acc(1'h1, 1'h1, 22'h0abcd, 16'h77ff, 2'h2);
		chk(snap, 9'h156);
		acc(1'h1, 1'h0, 22'h0abcd, 16'h0, 2'h3);
		chk({snap, rdata}, {9'h124, 16'h77ee});
		acc(1'h1, 1'h0, 22'h0abcd, 16'h0, 2'h1);
		chk(rdata[7:0], 8'hee);
	endtask : t_ram
	task t_pins;
		#4 {sleep, bprot, rdy} = 3'h6;
		repeat (3) @(posedge clk);
		#1 chk({mode, bpn, frdy}, 3'h0);
		acc(1'h1, 1'h0, 22'h0abcd, 16'h0, 2'h3);
		chk({snap[2], rdata}, {1'h1, 16'h0});
		#4 {sleep, bprot, rdy, frst} = 4'h3;
		repeat (3) @(posedge clk);
		#1 chk({mode, bpn, frdy, frn}, 4'he);
		#4 {die, req} = 2'h1;
		@(posedge clk);
		#5 req = 1'h0;
		@(posedge clk);
		#1 chk({busy, fcs}, 2'h1);
		acc(1'h1, 1'h0, 22'h5, 16'h0, 2'h3);
		chk(snap[8:7], 2'h2);
		#4 frst = 1'h0;
	endtask : t_pins
	task t_busy;
		acc(1'h0, 1'h1, 22'h100000, 16'h00aa, 2'h3);
		chk(frdy, 1'h0);
		acc(1'h0, 1'h0, 22'h200000, 16'h0, 2'h3);
		chk(rdata, 16'h5a5a);
		acc(1'h0, 1'h0, 22'h100000, 16'h0, 2'h3);
		chk(rdata, 16'h0040);
		acc(1'h0, 1'h1, 22'h100000, 16'h00b0, 2'h3);
		chk(frdy, 1'h1);
		acc(1'h0, 1'h0, 22'h100000, 16'h0, 2'h3);
		chk(rdata, 16'h5a5a);
		acc(1'h0, 1'h1, 22'h100000, 16'h0030, 2'h3);
		chk(frdy, 1'h0);
		repeat (40) @(posedge clk);
		#1 chk(frdy, 1'h1);
		#4 bprot = 1'h1;
		acc(1'h0, 1'h1, 22'h0, 16'h0055, 2'h3);
		chk(frdy, 1'h1);
		acc(1'h0, 1'h1, 22'h3ff000, 16'h0055, 2'h3);
		chk(frdy, 1'h1);
		acc(1'h0, 1'h1, 22'h008000, 16'h0055, 2'h3);
		chk(frdy, 1'h0);
		#4 bprot = 1'h0;
	endtask : t_busy
	initial
	begin
		#200000 mismatches++;
		tally_and_finish();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		#5 rstn = 1'h1;
		#1 chk({fcs, rcs, oe, we, lb, ub, mode, frn, bpn, busy}, 10'h3fe);
		t_flash();
		t_bank();
		t_ram();
		t_pins();
		t_busy();
		tally_and_finish();
	end
endmodule : flash_ram_shared_bus_decode_test
`default_nettype wire
